// *** hdl/cfg_sideband_pkg.sv ***
// Constants shared by the configuration sideband and completion error ends.
// ****************************************************************
// What this block does
// - Export eight 3-bit traffic class to channel entries.
// - Traffic class 0 entry always reads zero.
// - Application picks channel from exported map.
// - Export bus number high, device number low.
// - Application builds IDs with function number zero.
// - Export primary command and status register.
// - Export device control and status register.
// - Export link control and status register.
// - Application flags completion timeout on bit 0.
// - Device emits message for completion timeout.
// - Application sends abort completion, then flags bit 1.
// - Device emits message for completer abort.
// - Application flags unexpected completion on bit 2.
// - Application holds pending while completions are owed.
// - Low-power entry waits until pending deasserts.
// ****************************************************************
package cfg_sideband_pkg;
	localparam int unsigned TC_COUNT         = 8;
	localparam int unsigned VC_FIELD_W       = 3;
	localparam int unsigned TCVC_MAP_W       = 24;
	localparam int unsigned BUS_NUM_W        = 8;
	localparam int unsigned DEV_NUM_W        = 5;
	localparam int unsigned BUSDEV_W         = 13;
	localparam int unsigned BUS_NUM_LSB      = 5;
	localparam int unsigned DEV_NUM_LSB      = 0;
	localparam int unsigned CSR_W            = 32;
	localparam int unsigned CPL_ERR_W        = 3;
	localparam int unsigned ERR_TIMEOUT_BIT  = 0;
	localparam int unsigned ERR_ABORT_BIT    = 1;
	localparam int unsigned ERR_UNEXP_BIT    = 2;
	localparam logic [2:0]  TC0_VC           = 3'h0;
	localparam logic [31:0] CSR_RESET        = 32'h0000_0000;
	localparam logic [12:0] BUSDEV_RESET     = 13'h0000;
	localparam logic [23:0] TCVC_RESET       = 24'h00_0000;
	localparam logic [2:0]  FUNC_NUM         = 3'h0;
	// Completion timeout, ms, and cycles at 250 MHz (kept as a parameter).
	localparam int unsigned CPL_TIMEOUT_MS   = 50;
	localparam int unsigned CLK_KHZ          = 250000;
	localparam int unsigned CPL_TIMEOUT_CYC  = CPL_TIMEOUT_MS * CLK_KHZ;
	localparam int unsigned MSG_CNT_W        = 16;
endpackage : cfg_sideband_pkg

// *** hdl/cfg_sideband_if.sv ***
// Interface joining the endpoint sideband end and the application end.
`timescale 1ns/10ps
interface cfg_sideband_if;
	logic [23:0] tcvc_map;
	logic [12:0] bus_dev;
	logic [31:0] prim_csr;
	logic [31:0] dev_csr;
	logic [31:0] link_csr;
	logic [2:0]  cpl_err;
	logic        cpl_pending;

	modport core (
		output tcvc_map,
		output bus_dev,
		output prim_csr,
		output dev_csr,
		output link_csr,
		input  cpl_err,
		input  cpl_pending
	);

	modport app (
		input  tcvc_map,
		input  bus_dev,
		input  prim_csr,
		input  dev_csr,
		input  link_csr,
		output cpl_err,
		output cpl_pending
	);
endinterface : cfg_sideband_if

// *** hdl/cfg_sideband_core.sv ***
// Endpoint end: exports configuration values, turns errors into messages.
`timescale 1ns/10ps
module cfg_sideband_core (
	input  wire logic        clock,
	input  wire logic        rst,
	cfg_sideband_if.core     sb,
	input  wire logic [20:0] cfg_tc_map_in,
	input  wire logic [12:0] cfg_busdev_in,
	input  wire logic [31:0] cfg_prim_csr_in,
	input  wire logic [31:0] cfg_dev_csr_in,
	input  wire logic [31:0] cfg_link_csr_in,
	input  wire logic        lp_req,
	input  wire logic        msg_ready,
	output logic             lp_enter,
	output logic             msg_valid,
	output logic [2:0]       msg_err_type,
	output logic [15:0]      err_count
);
	// ****************************************************************
	// Configuration export
	// ****************************************************************

	// Next value of the exported map, one 3-bit field per class.
	wire logic [23:0] next_tcvc_map;

	// TC0 entry pinned.
	// Class 0 has no input field; it is tied so no setting can move it.
	assign next_tcvc_map[2:0] = cfg_sideband_pkg::TC0_VC;

	// ascending class fields.
	// Input field tc-1 feeds map field tc, so TC1 sits just above TC0.
	for (genvar tc = 1; tc < cfg_sideband_pkg::TC_COUNT; tc++) begin : g_tc
		assign next_tcvc_map[tc * 3 +: 3] = cfg_tc_map_in[(tc - 1) * 3 +: 3];
	end

	// Registered copies so the application sees glitch-free values.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sb.tcvc_map <= cfg_sideband_pkg::TCVC_RESET;
		end else begin
			sb.tcvc_map <= next_tcvc_map;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sb.bus_dev <= cfg_sideband_pkg::BUSDEV_RESET;
		end else begin
			sb.bus_dev <= cfg_busdev_in;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sb.prim_csr <= cfg_sideband_pkg::CSR_RESET;
			sb.dev_csr  <= cfg_sideband_pkg::CSR_RESET;
			sb.link_csr <= cfg_sideband_pkg::CSR_RESET;
		end else begin
			sb.prim_csr <= cfg_prim_csr_in;
			sb.dev_csr  <= cfg_dev_csr_in;
			sb.link_csr <= cfg_link_csr_in;
		end
	end

	// ****************************************************************
	// Error message generation
	// ****************************************************************

	// Pending errors; a new pulse sets a bit even as it is sent.
	logic      [2:0] err_pend;
	wire logic [2:0] next_err_pend;
	logic      [2:0] send_sel;
	logic      [2:0] next_msg_type;

	// Lowest bit goes first; others wait without being lost.
	always_comb begin
		send_sel = 3'h0;
		if (err_pend[cfg_sideband_pkg::ERR_TIMEOUT_BIT]) begin
			send_sel = 3'h1;
		end else if (err_pend[cfg_sideband_pkg::ERR_ABORT_BIT]) begin
			send_sel = 3'h2;
		end else if (err_pend[cfg_sideband_pkg::ERR_UNEXP_BIT]) begin
			send_sel = 3'h4;
		end
	end

	// One flag per error type. Set wins over clear: a pulse that lands
	// in the cycle its own type is taken leaves the flag up, so the
	// event is reported again rather than lost.
	// Pulses of one type that meet a raised flag merge into one message.
	for (genvar b = 0; b < cfg_sideband_pkg::CPL_ERR_W; b++) begin : g_err
		wire logic taken;

		// The flag clears only when its own message is accepted.
		assign taken = msg_valid && msg_ready && msg_err_type[b];

		assign next_err_pend[b] = sb.cpl_err[b] || (err_pend[b] && !taken);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			err_pend <= 3'h0;
		end else begin
			err_pend <= next_err_pend;
		end
	end

	// The type leaving this cycle still shows in its flag until the
	// edge, so it is masked here; the cost is one idle cycle between
	// messages, which keeps the priority logic off the accept path.
	always_comb begin
		next_msg_type = send_sel;
		if (msg_valid) begin
			next_msg_type = send_sel & ~msg_err_type;
		end
	end

	// Message held stable until accepted by the transmit path.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			msg_valid    <= 1'b0;
			msg_err_type <= 3'h0;
		end else if (!msg_valid || msg_ready) begin
			msg_valid    <= next_msg_type != 3'h0;
			msg_err_type <= next_msg_type;
		end
	end

	// Count of cycles with any error pulse, so pulses in one cycle count once; saturates rather than wraps.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			err_count <= 16'h0000;
		end else if (sb.cpl_err != 3'h0 && err_count != 16'hffff) begin
			err_count <= err_count + 16'h0001;
		end
	end

	// ****************************************************************
	// Low-power gating
	// ****************************************************************

	// Running, held off by an owed completion, or in low power.
	// Entry only happens while no completion is owed.
	typedef enum logic [1:0] {
		LP_RUN,
		LP_HELD,
		LP_LOW
	} lp_state_t;

	lp_state_t lp_state;
	lp_state_t next_lp_state;

	// A request that meets a pending completion waits in the held state.
	// A completion owed while in low power drops back to held, so the
	// application is never left waiting on a sleeping link.
	// hold off on pending.
	always_comb begin
		next_lp_state = lp_state;
		unique case (lp_state)
			LP_RUN: begin
				if (lp_req && !sb.cpl_pending) begin
					next_lp_state = LP_LOW;
				end else if (lp_req) begin
					next_lp_state = LP_HELD;
				end
			end
			LP_HELD: begin
				if (!lp_req) begin
					next_lp_state = LP_RUN;
				end else if (!sb.cpl_pending) begin
					next_lp_state = LP_LOW;
				end
			end
			LP_LOW: begin
				if (!lp_req) begin
					next_lp_state = LP_RUN;
				end else if (sb.cpl_pending) begin
					next_lp_state = LP_HELD;
				end
			end
			default: begin
				next_lp_state = LP_RUN;
			end
		endcase
	end

	// The spare fourth code falls back to running on the next edge.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lp_state <= LP_RUN;
		end else begin
			lp_state <= next_lp_state;
		end
	end

	// The output is its own flop, set for the state being entered.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lp_enter <= 1'b0;
		end else begin
			lp_enter <= next_lp_state == LP_LOW;
		end
	end
endmodule : cfg_sideband_core

// *** hdl/cfg_sideband_app.sv ***
// Application end: forms IDs, picks channels, reports completion errors.
`timescale 1ns/10ps
module cfg_sideband_app (
	input  wire logic        clock,
	input  wire logic        rst,
	cfg_sideband_if.app      sb,
	input  wire logic [2:0]  pkt_tc,
	input  wire logic        req_issue,
	input  wire logic        cpl_recv,
	input  wire logic        abort_cpl_sent,
	output logic [2:0]       pkt_vc,
	output logic [15:0]      req_id,
	output logic             timeout_seen
);
	// Time limit in cycles; shorten for simulation.
	parameter int unsigned TIMEOUT_CYC = cfg_sideband_pkg::CPL_TIMEOUT_CYC;

	logic [7:0]  outstanding;
	logic [31:0] wait_cnt;
	logic        unexp;
	logic        expire;

	assign unexp  = cpl_recv && outstanding == 8'h00;
	assign expire = outstanding != 8'h00 && wait_cnt >= TIMEOUT_CYC - 1;

	// ****************************************************************
	// Packet header fields
	// ****************************************************************

	// Lookups registered so outputs come straight from flip-flops.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pkt_vc <= 3'h0;
			req_id <= 16'h0000;
		end else begin
			pkt_vc <= sb.tcvc_map[pkt_tc * 3 +: 3];
			req_id <= {sb.bus_dev, cfg_sideband_pkg::FUNC_NUM};
		end
	end

	// ****************************************************************
	// Outstanding request tracking
	// ****************************************************************

	// One shared timer; restarts on any completion, a simple trade-off.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			outstanding <= 8'h00;
			wait_cnt    <= 32'h0;
		end else begin
			if (expire) begin
				outstanding <= 8'h00;
			end else if (req_issue && !(cpl_recv && !unexp)) begin
				outstanding <= outstanding + 8'h01;
			end else if (!req_issue && cpl_recv && !unexp) begin
				outstanding <= outstanding - 8'h01;
			end
			if (outstanding == 8'h00 || cpl_recv || expire) begin
				wait_cnt <= 32'h0;
			end else begin
				wait_cnt <= wait_cnt + 32'h1;
			end
		end
	end

	// ****************************************************************
	// Error pulses and pending flag
	// ****************************************************************

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sb.cpl_err   <= 3'h0;
			sb.cpl_pending <= 1'b0;
			timeout_seen <= 1'b0;
		end else begin
			sb.cpl_err[cfg_sideband_pkg::ERR_TIMEOUT_BIT] <= expire;
			sb.cpl_err[cfg_sideband_pkg::ERR_ABORT_BIT] <= abort_cpl_sent;
			sb.cpl_err[cfg_sideband_pkg::ERR_UNEXP_BIT] <= unexp;
			sb.cpl_pending <= (outstanding != 8'h00 && !expire) || req_issue;
			timeout_seen <= timeout_seen | expire;
		end
	end
endmodule : cfg_sideband_app

// *** tb/cfg_sideband_assertions.sv ***
// Checks on the sideband signals between the two ends.
`timescale 1ns/10ps
module cfg_sideband_assertions #(
	parameter int unsigned TIMEOUT_CYC = 20
) (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic [23:0] tcvc_map,
	input wire logic [2:0]  cpl_err,
	input wire logic        cpl_pending
);
	// Length of the current pending run; a timeout needs a long wait.
	logic [15:0] pend_run;
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			pend_run <= 16'h0;
		else
			pend_run <= cpl_pending ? pend_run + 16'h1 : 16'h0;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ****************************************
	// Properties
	// ****************************************
	sequence s_to_fire;
		cpl_err[0] ##1 !cpl_err[0];
	endsequence
	property p_tc0_zero; tcvc_map[2:0] == 3'h0; endproperty
	property p_one_shot; (cpl_err & $past(cpl_err)) == 3'h0; endproperty
	property p_to_pend; cpl_err[0] |-> $past(cpl_pending); endproperty
	property p_to_wait;
		cpl_err[0] |-> pend_run >= 16'(TIMEOUT_CYC);
	endproperty
	property p_to_clears; s_to_fire |-> ##1 !cpl_pending; endproperty
	property p_to_once; s_to_fire |-> !cpl_err[0] [*8]; endproperty
	property p_unexp_idle; cpl_err[2] |-> !$past(cpl_pending); endproperty
	property p_rst_clear;
		$fell(rst) |-> cpl_err == 3'h0 && !cpl_pending;
	endproperty
	a_tc0_zero: assert property (p_tc0_zero)
		else $error("tc0 entry not zero");
	a_one_shot: assert property (p_one_shot)
		else $error("error bit high two cycles");
	a_to_pend: assert property (p_to_pend)
		else $error("timeout without pending request");
	a_to_wait: assert property (p_to_wait)
		else $error("timeout too early");
	a_to_clears: assert property (p_to_clears)
		else $error("pending kept after timeout");
	a_to_once: assert property (p_to_once)
		else $error("timeout reported twice");
	a_unexp_idle: assert property (p_unexp_idle)
		else $error("unexpected flagged while pending");
	a_rst_clear: assert property (p_rst_clear)
		else $error("link not idle after reset");
endmodule : cfg_sideband_assertions

// *** tb/pcie_cfg_sideband_cpl_error_if_test.sv ***
// Self-checking bench joining the core end and the application end.
`timescale 1ns/10ps
module pcie_cfg_sideband_cpl_error_if_test;
	logic        clock = 0, rst = 1, lp_req = 0, msg_ready = 0;
	logic        req_issue = 0, cpl_recv = 0, abort_sent = 0;
	logic        lp_enter, msg_valid, timeout_seen;
	logic [20:0] map_in = '0;
	logic [12:0] busdev_in = '0;
	logic [31:0] prim_in = '0, dev_in = '0, link_in = '0, seed = 32'h1e;
	logic [2:0]  pkt_tc = '0, msg_err_type, pkt_vc;
	logic [15:0] err_count, req_id;
	logic [2:0]  exp_q[$];
	logic [31:0] rbits = '0;
	int          err_total = 0, checks_done = 0, cyc = 0, exp_cnt = 0;
	cfg_sideband_if cfg_sideband_if_i ();
	cfg_sideband_core cfg_sideband_core_i (.clock(clock), .rst(rst),
		.sb(cfg_sideband_if_i), .cfg_tc_map_in(map_in),
		.cfg_busdev_in(busdev_in), .cfg_prim_csr_in(prim_in),
		.cfg_dev_csr_in(dev_in), .cfg_link_csr_in(link_in),
		.lp_req(lp_req), .msg_ready(msg_ready), .lp_enter(lp_enter),
		.msg_valid(msg_valid), .msg_err_type(msg_err_type),
		.err_count(err_count));
	cfg_sideband_app #(.TIMEOUT_CYC(20)) cfg_sideband_app_i (.clock(clock),
		.rst(rst), .sb(cfg_sideband_if_i), .pkt_tc(pkt_tc),
		.req_issue(req_issue), .cpl_recv(cpl_recv),
		.abort_cpl_sent(abort_sent), .pkt_vc(pkt_vc), .req_id(req_id),
		.timeout_seen(timeout_seen));
	cfg_sideband_assertions #(.TIMEOUT_CYC(20)) cfg_sideband_assertions_i (
		.clock(clock), .rst(rst), .tcvc_map(cfg_sideband_if_i.tcvc_map),
		.cpl_err(cfg_sideband_if_i.cpl_err),
		.cpl_pending(cfg_sideband_if_i.cpl_pending));
	// Free-running 250 MHz clock.
	always #2 clock = ~clock;
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			err_total++;
			$display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	// Waits, bounded, until every noted message has been taken.
	task automatic drain();
		for (int i = 0; i < 60 && exp_q.size() > 0; i++)
			tick(1);
	endtask : drain
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// Random ready stalls force messages to stand; a ceiling cuts hangs.
	always @(posedge clock) begin
		msg_ready <= 1'(rnd() >> 7);
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			print_verdict();
		end
	end
	// Each message taken must match the oldest note; none may be spare.
	always @(posedge clock) begin
		if (!rst && msg_valid && msg_ready) begin
			if (exp_q.size() == 0)
				check(msg_err_type, 3'h0);
			else
				check(msg_err_type, exp_q.pop_front());
		end
	end
	// Main sequence: exports, error reports, timeout and low power.
	initial begin
		tick(2);
		rst <= 0;
		repeat (3) begin
			map_in <= 21'(rnd());
			busdev_in <= 13'(rnd());
			prim_in <= rnd();
			dev_in <= rnd();
			link_in <= rnd();
			tick(3);
			check(cfg_sideband_if_i.tcvc_map, {map_in, 3'h0});
			check(cfg_sideband_if_i.tcvc_map[2:0], 3'h0);
			check(cfg_sideband_if_i.bus_dev, busdev_in);
			check(cfg_sideband_if_i.prim_csr, prim_in);
			check(cfg_sideband_if_i.dev_csr, dev_in);
			check(cfg_sideband_if_i.link_csr, link_in);
			check(req_id, {busdev_in, 3'h0});
			for (int tc = 0; tc < 8; tc++) begin
				pkt_tc <= 3'(tc);
				tick(2);
				check(pkt_vc, 3'({map_in, 3'h0} >> (3 * tc)));
			end
		end
		$display("test exports done");
		// Random lone abort pulses and low-power requests while idle.
		repeat (6) begin
			rbits = rnd();
			abort_sent <= rbits[0];
			lp_req <= rbits[1];
			if (rbits[0]) begin
				exp_q.push_back(3'h2);
				exp_cnt++;
			end
			tick(1);
			abort_sent <= 0;
			tick(1);
			check(lp_enter, 32'(rbits[1]));
			drain();
		end
		lp_req <= 0;
		$display("test random aborts done");
		// Abort then unexpected back to back, then both in one cycle.
		exp_q.push_back(3'h2);
		abort_sent <= 1;
		tick(1);
		abort_sent <= 0;
		exp_q.push_back(3'h4);
		cpl_recv <= 1;
		tick(1);
		cpl_recv <= 0;
		drain();
		exp_q.push_back(3'h2);
		exp_q.push_back(3'h4);
		abort_sent <= 1;
		cpl_recv <= 1;
		tick(1);
		abort_sent <= 0;
		cpl_recv <= 0;
		drain();
		$display("test error reports done");
		// Unanswered request times out; low power waits on pending.
		exp_q.push_back(3'h1);
		req_issue <= 1;
		lp_req <= 1;
		tick(1);
		req_issue <= 0;
		tick(5);
		check(lp_enter, 1'b0);
		tick(30);
		check(timeout_seen, 1'b1);
		check(lp_enter, 1'b1);
		req_issue <= 1;
		tick(1);
		req_issue <= 0;
		tick(4);
		check(lp_enter, 1'b0);
		cpl_recv <= 1;
		tick(1);
		cpl_recv <= 0;
		tick(3);
		check(lp_enter, 1'b1);
		drain();
		check(32'(exp_q.size()), 32'h0);
		check(err_count, 32'h4 + 32'(exp_cnt));
		$display("test timeout and low power done");
		print_verdict();
	end
endmodule : pcie_cfg_sideband_cpl_error_if_test
